// *** dv/dpw_host_model.sv ***
// Purpose: host side driving the wiper pins
// Assumes: pins move on falling ref_clk, 125 ns link clock
// Notes: link clock stands low between tasks
module dpw_host_model
(
  // clock
  input wire logic ref_clk,
  // host pins
  output logic chipSelectN,
  output logic serialClk,
  output logic serialDin
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle pins
  initial
  begin
    chipSelectN = 1'b1;
    serialClk = 1'b0;
    serialDin = 1'b0;
  end
  // wait falling edges
  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wt
  // one frame msb first, select held low throughout
  task automatic frame(input logic [23:0] word, input int n);
    chipSelectN = 1'b0;
    wt(12);
    for (int i = 0; i < n; i++)
    begin
      serialDin = word[23 - i];
      wt(12);
      serialClk = 1'b1;
      wt(13);
      serialClk = 1'b0;
    end
    wt(12);
    chipSelectN = 1'b1;
    serialDin = ~serialDin;
    wt(12);
  endtask : frame
  // step pulses with direction up and select level cs
  task automatic step(input logic up, input int n, input logic cs);
    serialDin = up;
    chipSelectN = cs;
    wt(12);
    repeat (n)
    begin
      serialClk = 1'b1;
      wt(13);
      serialClk = 1'b0;
      wt(12);
    end
  endtask : step
  // deselect, clock level picks store or not
  task automatic desel(input logic keep);
    serialClk = keep;
    wt(12);
    chipSelectN = 1'b1;
    wt(12);
    serialClk = 1'b0;
    wt(12);
  endtask : desel
endmodule : dpw_host_model

// *** dv/dpw_wiper_ctrl_bench.sv ***
// Purpose: self-checking bench for the wiper block
// Assumes: store time shortened to 20 cycles
// Notes: pins driven by the host model
module dpw_wiper_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic interfaceSelect = 1'b1;
  logic clkEn = 1'b1;
  logic chipSelectN, serialClk, serialDin, storeBusy;
  logic [9:0] wiperPos, persistentStore;
  int fails = 0;
  int checksDone = 0;
  // frame rows: length, word, expected wiper
  int rowLen [7] = '{24, 24, 24, 24, 24, 23, 8};
  logic [23:0] rowWord [7] = '{24'h00003f, 24'h00ffff, 24'h00557f,
    24'h00aabf, 24'h10003f, 24'h00557f, 24'h000000};
  logic [9:0] rowExp [7] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa, 10'h2aa,
    10'h2aa, 10'h2aa};
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // parts
  dpw_host_model host (.ref_clk, .chipSelectN, .serialClk, .serialDin);
  dpw_wiper_ctrl #(.STORE_CYCLES(20)) dut (.ref_clk, .reset, .clkEn,
    .interfaceSelect, .chipSelectN, .serialClk, .serialDin, .wiperPos,
    .persistentStore, .storeBusy);
  // compare and count
  task automatic chk(input string what, input logic [9:0] seen,
    input logic [9:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // verdict
  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  // watchdog
  initial
  begin
    #400000;
    fails++;
    conclude();
  end
  // sequence
  initial
  begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    host.wt(6);
    for (int r = 0; r < 7; r++)
    begin
      host.frame(rowWord[r], rowLen[r]);
      chk("row", wiperPos, rowExp[r]);
    end
    host.frame(24'h200000, 8);
    chk("busy", {9'h000, storeBusy}, 10'h001);
    host.wt(30);
    chk("save", persistentStore, 10'h2aa);
    host.frame(24'h0003ff, 24);
    chk("keep", persistentStore, 10'h2aa);
    host.frame(24'h30ffff, 24);
    chk("load", wiperPos, 10'h2aa);
    clkEn = 1'b0;
    host.frame(24'h00003f, 24);
    clkEn = 1'b1;
    host.wt(6);
    chk("frozen", wiperPos, 10'h2aa);
    host.frame(24'h00ffbf, 24);
    interfaceSelect = 1'b0;
    host.step(1'b1, 2, 1'b0);
    host.desel(1'b0);
    chk("top", wiperPos, 10'h3ff);
    chk("nosave", persistentStore, 10'h2aa);
    host.step(1'b0, 2, 1'b1);
    chk("off", wiperPos, 10'h3ff);
    host.step(1'b0, 3, 1'b0);
    host.desel(1'b1);
    chk("down", wiperPos, 10'h3fc);
    host.wt(30);
    chk("stepsave", persistentStore, 10'h3fc);
    interfaceSelect = 1'b1;
    host.frame(24'h00007f, 24);
    interfaceSelect = 1'b0;
    host.step(1'b0, 2, 1'b0);
    host.desel(1'b0);
    chk("bottom", wiperPos, 10'h000);
    interfaceSelect = 1'b1;
    reset = 1'b1;
    host.wt(3);
    reset = 1'b0;
    host.wt(6);
    chk("boot", wiperPos, 10'h3fc);
    conclude();
  end
endmodule : dpw_wiper_ctrl_bench

// *** dv/dpw_wiper_ctrl_checker.sv ***
// Purpose: pin level assertions for the wiper block
// Assumes: clkEn high while a store runs
// Notes: bound below
`include "dpw_map.svh"

module dpw_wiper_ctrl_checker
  import dpw_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = `DPW_STORE_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // host pins
  input wire logic interfaceSelect,
  input wire logic chipSelectN,
  input wire logic serialDin,
  // wiper and status
  input wire logic [9:0] wiperPos,
  input wire logic [9:0] persistentStore,
  input wire logic storeBusy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  bit seenStore;
  int busyRun;
  ////////////////////////////////////////////////////////////////////////////
  // remember that the store holds a value
  always_ff @(posedge ref_clk)
  begin
    if (storeBusy)
      seenStore <= 1'b1;
  end
  // length of the current busy run in ref_clk cycles
  always_ff @(posedge ref_clk)
  begin
    busyRun <= storeBusy ? busyRun + 1 : 0;
  end
  // stepping port open, then a move
  sequence stepWin;
    (!interfaceSelect && !chipSelectN) [*8];
  endsequence
  sequence stepUp;
    stepWin ##0 (wiperPos == $past(wiperPos) + 10'h001);
  endsequence
  sequence stepDown;
    stepWin ##0 (wiperPos == $past(wiperPos) - 10'h001);
  endsequence
  busy_span_a:
    assert property ($rose(storeBusy) |-> storeBusy [*8] ##[10:16] !storeBusy)
    else $error("store busy span wrong");
  busy_hold_a:
    assert property (storeBusy |-> $stable(wiperPos))
    else $error("wiper moved while busy");
  step_up_a:
    assert property (stepUp |-> serialDin) else $error("wrong direction up");
  step_down_a:
    assert property (stepDown |-> !serialDin) else $error("wrong direction");
  step_sat_a:
    assert property (stepWin ##0 ($past(wiperPos) == {10{serialDin}})
      |-> wiperPos == $past(wiperPos)) else $error("wiper wrapped");
  store_copy_a:
    assert property ($rose(storeBusy) |-> ##[0:2] persistentStore == wiperPos)
    else $error("store not copied");
  boot_load_a:
    assert property (seenStore && $fell(reset)
      |-> ##[1:2] wiperPos == persistentStore) else $error("boot load wrong");
  serial_latch_a:
    assert property (interfaceSelect && $changed(wiperPos)
      |-> $past(chipSelectN, 2)) else $error("wiper moved in frame");
  busy_length_a:
    assert property ($fell(storeBusy) |-> busyRun == STORE_CYCLES)
    else $error("store busy time wrong");
  step_off_a:
    assert property ((!interfaceSelect && chipSelectN) [*8]
      |-> $stable(wiperPos)) else $error("wiper moved while deselected");
endmodule : dpw_wiper_ctrl_checker

bind dpw_wiper_ctrl dpw_wiper_ctrl_checker #(.STORE_CYCLES(STORE_CYCLES)) chk
  (.ref_clk, .reset, .interfaceSelect, .chipSelectN, .serialDin, .wiperPos,
  .persistentStore, .storeBusy);

// *** rtl/dpw_map.svh ***
// Purpose: offsets, widths, resets and timing counts for the wiper block
// Assumes: ref_clk at 200 MHz
// Notes: definitions only
`ifndef DPW_MAP_SVH
`define DPW_MAP_SVH

`define DPW_POS_W 10
`define DPW_POS_MAX 10'h3ff
`define DPW_POS_MIN 10'h000
`define DPW_NV_RESET 10'h200
`define DPW_FRAME_LONG 5'h18
`define DPW_FRAME_SHORT 5'h08
`define DPW_CNT_MAX 5'h1f
`define DPW_CMD_HI_BIT 21
`define DPW_CMD_LO_BIT 20
`define DPW_POS_TOP 15
`define DPW_POS_BOT 6
`define DPW_SHORT_HI_BIT 5
`define DPW_SHORT_LO_BIT 4
`define DPW_STORE_MS 12
`define DPW_CLK_MHZ 200
`define DPW_STORE_CYC (`DPW_STORE_MS * 1000 * `DPW_CLK_MHZ)

`endif

// *** rtl/dpw_pkg.sv ***
// Purpose: types for the wiper block
// Assumes: nothing
// Notes: command codes and control states
package dpw_pkg;

  typedef enum logic [1:0]
  {
    DPW_CMD_WRITE = 2'h0,
    DPW_CMD_RSVD = 2'h1,
    DPW_CMD_SAVE = 2'h2,
    DPW_CMD_LOAD = 2'h3
  } dpw_cmd_e;

  // gray order: boot -> idle -> busy
  typedef enum logic [1:0]
  {
    DPW_ST_BOOT = 2'h0,
    DPW_ST_IDLE = 2'h1,
    DPW_ST_BUSY = 2'h3
  } dpw_state_e;

  typedef struct packed
  {
    logic [2:0] csSync;
    logic [2:0] clkSync;
    logic [2:0] dinSync;
    logic csStable;
    logic clkStable;
    logic dinStable;
    logic [23:0] shift;
    logic [4:0] bitCnt;
    logic [9:0] wiper;
    logic [9:0] store;
    logic [31:0] busyCnt;
    dpw_state_e state;
  } dpw_state_s;

endpackage : dpw_pkg

// *** rtl/dpw_wiper_ctrl.sv ***
// Purpose: wiper position control behind a serial or up/down port
// Assumes: host pins are asynchronous to ref_clk
// Notes: the persistent store is a register that reset leaves alone,
//   so it stays unknown in simulation until the first store
//   each pin level except interfaceSelect must be sampled on two ref_clk edges in a row to be seen
//   all pins are ignored for the whole store time
//   frames of other lengths than 8 or 24 clocks are dropped
//
// Behaviour
// R1: select pin picks serial or stepping port
// R2: step falling edge moves by direction
// R3: steps only while chip select low
// R4: wiper is a ten bit position
// R5: zero is low end, 1023 high end
// R6: serial data shifts on clock rise
// R7: serial port is receive only
// R8: host sends write frames of 24 clocks
// R9: copy frames are 8 or 24 clocks
// R10: chip select rise executes command
// R11: host keeps chip select low whole frame
// R12: fixed frame bit layout, msb first
// R13: write changes volatile wiper only
// R14: power up loads stored position
// R15: save copies wiper, busy 12 ms
// R16: load copies store into wiper
// R17: stepping deselect with step high stores
// R18: stepping port enabled by chip select low
// R19: stepping saturates at both ends
`include "dpw_map.svh"

module dpw_wiper_ctrl
  import dpw_pkg::*;
#(
  parameter int unsigned STORE_CYCLES = `DPW_STORE_CYC
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  // host pins
  input wire logic interfaceSelect,
  input wire logic chipSelectN,
  input wire logic serialClk,
  input wire logic serialDin,
  // wiper and status
  output logic [9:0] wiperPos,
  output logic [9:0] persistentStore,
  output logic storeBusy
);

  dpw_state_s st_q;
  dpw_state_s st_d;

  ////////////////////////////////////////////////////////////////////////////
  // edge detection helpers
  logic csRise;
  logic clkRise;
  logic clkFall;
  logic csSettled;
  logic clkSettled;
  logic dinSettled;
  logic bitTake;
  logic stepEdge;
  logic stepStore;
  logic atTop;
  logic atBottom;
  logic frameLong;
  logic frameShort;
  logic [9:0] framePos;
  dpw_cmd_e cmdLong;
  dpw_cmd_e cmdShort;
  dpw_cmd_e cmd;

  // a level counts once sync stages two and three agree
  assign csSettled = (st_q.csSync[1] == st_q.csSync[2]) ?
                     st_q.csSync[2] : st_q.csStable;
  assign clkSettled = (st_q.clkSync[1] == st_q.clkSync[2]) ?
                      st_q.clkSync[2] : st_q.clkStable;
  assign dinSettled = (st_q.dinSync[1] == st_q.dinSync[2]) ?
                      st_q.dinSync[2] : st_q.dinStable;
  assign csRise = csSettled & ~st_q.csStable;
  assign clkRise = clkSettled & ~st_q.clkStable;
  assign clkFall = ~clkSettled & st_q.clkStable;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame decode, used in the cycle chip select rises

  // a bit is taken on a settled clock rise; the count stops at its top
  assign bitTake = ~csSettled & clkRise &
                   (st_q.bitCnt != `DPW_CNT_MAX); // R6

  // only two lengths carry a command; anything else is dropped
  assign frameLong = (st_q.bitCnt == `DPW_FRAME_LONG); // R8
  assign frameShort = (st_q.bitCnt == `DPW_FRAME_SHORT); // R9

  // command bits sit at fixed clock positions from the first bit
  assign cmdLong = dpw_cmd_e'({st_q.shift[`DPW_CMD_HI_BIT],
                               st_q.shift[`DPW_CMD_LO_BIT]}); // R12
  assign cmdShort = dpw_cmd_e'({st_q.shift[`DPW_SHORT_HI_BIT],
                                st_q.shift[`DPW_SHORT_LO_BIT]}); // R12

  // position field, msb first; the trailing bits are don't care
  assign framePos = st_q.shift[`DPW_POS_TOP:`DPW_POS_BOT]; // R12

  // command choice; a short write is refused, its data never came
  always_comb
  begin
    cmd = DPW_CMD_RSVD;
    if (frameLong)
    begin
      cmd = cmdLong; // R8
    end
    else if (frameShort && cmdShort != DPW_CMD_WRITE)
    begin
      cmd = cmdShort; // R9
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stepping decode

  // a settled fall of the step pin counts only with chip select low
  assign stepEdge = ~csSettled & clkFall; // R3
  // chip select rising while the step pin is high asks for a store
  assign stepStore = csRise & clkSettled; // R17
  // end stops, so the counter saturates instead of wrapping
  assign atTop = (st_q.wiper == `DPW_POS_MAX); // R19
  assign atBottom = (st_q.wiper == `DPW_POS_MIN); // R19

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_d = st_q;
    st_d.csSync = {st_q.csSync[1:0], chipSelectN};
    st_d.clkSync = {st_q.clkSync[1:0], serialClk};
    st_d.dinSync = {st_q.dinSync[1:0], serialDin};
    st_d.csStable = csSettled;
    st_d.clkStable = clkSettled;
    st_d.dinStable = dinSettled;
    case (st_q.state)
      DPW_ST_BOOT:
      begin
        st_d.wiper = st_q.store; // R14
        st_d.state = DPW_ST_IDLE;
      end
      DPW_ST_BUSY:
      begin
        // store write in progress; host pins ignored
        if (st_q.busyCnt >= STORE_CYCLES - 1)
        begin
          st_d.state = DPW_ST_IDLE; // R15
        end
        st_d.busyCnt = st_q.busyCnt + 32'h1;
        st_d.bitCnt = 5'h00;
      end
      DPW_ST_IDLE:
      begin
        if (interfaceSelect) // R1
        begin
          // serial port: no output pin exists R7
          if (bitTake)
          begin
            st_d.shift = {st_q.shift[22:0], dinSettled}; // R6
            st_d.bitCnt = st_q.bitCnt + 5'h01;
          end
          if (csSettled)
          begin
            st_d.bitCnt = 5'h00;
          end
          if (csRise)
          begin
            // R10 decode on chip select rise
            case (cmd)
              DPW_CMD_WRITE:
              begin
                // R13 volatile only; R5 code maps straight to tap
                st_d.wiper = framePos; // R12
              end
              DPW_CMD_SAVE:
              begin
                st_d.store = st_q.wiper; // R15
                st_d.busyCnt = 32'h0;
                st_d.state = DPW_ST_BUSY;
              end
              DPW_CMD_LOAD:
              begin
                st_d.wiper = st_q.store; // R16
              end
              default:
              begin
                st_d.wiper = st_q.wiper; // bad length or code ignored
              end
            endcase
          end
        end
        else
        begin
          st_d.bitCnt = 5'h00;
          // R18 stepping active only with chip select low
          if (stepEdge) // R2 R3
          begin
            if (dinSettled && !atTop)
            begin
              st_d.wiper = st_q.wiper + 10'h001; // R19
            end
            else if (!dinSettled && !atBottom)
            begin
              st_d.wiper = st_q.wiper - 10'h001; // R19
            end
          end
          if (stepStore)
          begin
            st_d.store = st_q.wiper; // R17
            st_d.busyCnt = 32'h0;
            st_d.state = DPW_ST_BUSY;
          end
        end
      end
      default:
      begin
        st_d.state = DPW_ST_BOOT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; store keeps its value across reset like real memory
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      // sync stages start at the pin idle levels: no false edge
      st_q.csSync <= 3'h7;
      st_q.clkSync <= 3'h0;
      st_q.dinSync <= 3'h0;
      st_q.csStable <= 1'h1;
      st_q.clkStable <= 1'h0;
      st_q.dinStable <= 1'h0;
      st_q.shift <= 24'h000000;
      st_q.bitCnt <= 5'h00;
      // midscale until the boot state copies the store in
      st_q.wiper <= `DPW_NV_RESET;
      st_q.busyCnt <= 32'h0;
      st_q.state <= DPW_ST_BOOT;
      // store left out on purpose: it must survive reset
    end
    else if (clkEn)
    begin
      st_q.csSync <= st_d.csSync;
      st_q.clkSync <= st_d.clkSync;
      st_q.dinSync <= st_d.dinSync;
      st_q.csStable <= st_d.csStable;
      st_q.clkStable <= st_d.clkStable;
      st_q.dinStable <= st_d.dinStable;
      st_q.shift <= st_d.shift;
      st_q.bitCnt <= st_d.bitCnt;
      st_q.wiper <= st_d.wiper;
      st_q.busyCnt <= st_d.busyCnt;
      st_q.state <= st_d.state;
      // the store only moves when a save or a step store asks
      st_q.store <= st_d.store;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign wiperPos = st_q.wiper; // R4
  assign persistentStore = st_q.store;
  assign storeBusy = (st_q.state == DPW_ST_BUSY);

endmodule : dpw_wiper_ctrl
